// ### abp_pkg.sv
// Package for the address-phase block: widths, bit positions, timing counts.
// Assumes a single 25 MHz bus clock shared by both ends.
package abp_pkg;
	// ====================================
	// Widths
	localparam int ADDR_W      = 32;
	localparam int PAR_W       = 4;
	localparam int TAG_W       = 4;
	// ====================================
	// Reply packet layout on the first direct-store beat
	localparam int REPLY_FLAG_BIT = 31;
	localparam int TAG_LSB        = 24;
	// ====================================
	// Fault pin timing, in cycles after the strobe
	localparam int FAULT_ASSERT_CYC  = 2;
	localparam int FAULT_RELEASE_CYC = 3;
	// ====================================
	// Reset values
	localparam logic [31:0] ADDR_RST = 32'h0000_0000;
	localparam logic [3:0]  PAR_RST  = 4'h0;

	typedef enum logic [1:0] {
		ABP_IDLE  = 2'b00,
		ABP_BEAT0 = 2'b01,
		ABP_BEAT1 = 2'b11,
		ABP_HOLD  = 2'b10
	} abp_state_type;

	// Odd parity per byte: byte 0 is the most significant (lines 0-7)
	function automatic logic [3:0] abp_odd_par(input logic [31:0] a);
		logic [3:0] p;
		p = 4'h0;
		for (int i = 0; i < 4; i++) begin
			p[3 - i] = ~(^a[8 * i +: 8]);
		end
		return p;
	endfunction : abp_odd_par
endpackage : abp_pkg

// ### abp_bus_if.sv
// Bus interface joining the processor end and the system end.
// Assumes the bench resolves shared lines from the enables.
interface abp_bus_if;
	logic [31:0] dev_addr_o, dev_addr_oe, sys_addr_o;
	logic [3:0]  dev_par_o, sys_par_o;
	logic        dev_par_oe, sys_addr_oe;
	logic [31:0] addr_lines;
	logic [3:0]  addr_byte_parity;
	logic        dev_xbs_o, dev_xbs_oe, dev_bs_o, dev_bs_oe;
	logic        sys_xbs_o, sys_bs_o, sys_strobe_oe;
	logic        xfer_begin_strobe_n;
	logic        ext_xfer_begin_strobe_n;
	logic        addr_ack_in_n;
	logic        grant_n;
	logic        fault_o, fault_oe;
	logic        addr_parity_fault_out_n;

	modport dev (
		input  addr_lines, addr_byte_parity, xfer_begin_strobe_n,
		input  ext_xfer_begin_strobe_n, addr_ack_in_n, grant_n, addr_parity_fault_out_n,
		output dev_addr_o, dev_addr_oe, dev_par_o, dev_par_oe,
		output dev_xbs_o, dev_xbs_oe, dev_bs_o, dev_bs_oe, fault_o, fault_oe
	);
	modport sys (
		input  addr_lines, addr_byte_parity, xfer_begin_strobe_n,
		input  ext_xfer_begin_strobe_n, addr_parity_fault_out_n, dev_addr_oe,
		output sys_addr_o, sys_par_o, sys_addr_oe, sys_xbs_o, sys_bs_o,
		output sys_strobe_oe, addr_ack_in_n, grant_n
	);
endinterface : abp_bus_if

// ### abp_dev.sv
// Processor end of the address phase: masters memory and direct-store
// tenures, snoops other masters, checks parity and raises faults.
// Assumes grant and acknowledge are synchronous to clk, active low.
// Function
// RL1: Snoop address sampled only in strobe cycle
// RL2: Direct-store tenure: control packet, then address
// RL3: Reply beats carry control, status and tag
// RL4: First beat after grant with extended strobe
// RL5: Release address lines cycle after acknowledge
// RL6: Snoop first beat, match reply tag
// RL7: Other master presents beats on consecutive cycles
// RL8: Four odd-parity lines, one per byte
// RL9: Byte plus parity has odd ones count
// RL10: Parity error gives checkstop or machine check
// RL11: Memory address after grant with strobe
// RL12: Fault pin low second cycle, released third
// RL13: Per-byte check combined into one error
module abp_dev (
	input  wire logic  clk,
	input  wire logic  rst,
	abp_bus_if.dev     bus,
	input  wire logic  mem_req,
	input  wire logic  ds_req,
	input  wire logic  [31:0] req_addr,
	input  wire logic  [31:0] req_ctl_tag,
	input  wire logic  [3:0]  proc_tag_id,
	input  wire logic  impl_config_reg,
	input  wire logic  machine_check_enable,
	output logic       busy,
	output logic       reply_hit,
	output logic [31:0] reply_word,
	output logic       checkstop,
	output logic       machine_check
);
	// ====================================
	// Master sequencing
	abp_pkg::abp_state_type st_r, st_nxt;
	logic        is_ds_r;
	logic [31:0] addr_r, beat1_r;
	logic [31:0] drive_addr;
	logic        granted;
	logic        acked;

	assign granted = ~bus.grant_n && st_r == abp_pkg::ABP_IDLE && (mem_req || ds_req);
	assign acked   = ~bus.addr_ack_in_n;

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			abp_pkg::ABP_IDLE:  if (granted) st_nxt = abp_pkg::ABP_BEAT0;
			abp_pkg::ABP_BEAT0: st_nxt = acked ? abp_pkg::ABP_IDLE
				: (is_ds_r ? abp_pkg::ABP_BEAT1 : abp_pkg::ABP_HOLD); // RL4
			abp_pkg::ABP_BEAT1: if (acked) st_nxt = abp_pkg::ABP_IDLE; // RL5
			abp_pkg::ABP_HOLD:  if (acked) st_nxt = abp_pkg::ABP_IDLE; // RL5
		endcase
	end

	// Direct-store beat 0 is control/tag, beat 1 the physical address
	assign drive_addr = (st_nxt == abp_pkg::ABP_BEAT1) ? beat1_r : addr_r; // RL2

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r    <= abp_pkg::ABP_IDLE;
			is_ds_r <= 1'b0;
			addr_r  <= abp_pkg::ADDR_RST;
			beat1_r <= abp_pkg::ADDR_RST;
		end else begin
			st_r <= st_nxt;
			if (granted) begin
				is_ds_r <= ds_req;
				addr_r  <= ds_req ? req_ctl_tag : req_addr; // RL2 RL3 RL11
				beat1_r <= req_addr;
			end else if (st_nxt == abp_pkg::ABP_BEAT1) begin
				addr_r  <= beat1_r;
			end
		end
	end

	// ====================================
	// Pin drive: address, parity, strobes all registered
	logic        drv_r, bs_r, xbs_r;
	logic [31:0] aout_r;
	logic [3:0]  pout_r;
	logic        drv_nxt;
	assign drv_nxt = st_nxt != abp_pkg::ABP_IDLE;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			drv_r  <= 1'b0;
			bs_r   <= 1'b0;
			xbs_r  <= 1'b0;
			aout_r <= abp_pkg::ADDR_RST;
			pout_r <= abp_pkg::PAR_RST;
		end else begin
			drv_r  <= drv_nxt; // RL5
			bs_r   <= granted && !ds_req; // RL11
			xbs_r  <= granted && ds_req; // RL4
			aout_r <= granted ? (ds_req ? req_ctl_tag : req_addr) : drive_addr;
			pout_r <= abp_pkg::abp_odd_par(granted ? (ds_req ? req_ctl_tag : req_addr)
				: drive_addr); // RL8 RL9
		end
	end

	assign bus.dev_addr_o  = aout_r;
	assign bus.dev_addr_oe = {32{drv_r}};
	assign bus.dev_par_o   = pout_r; // RL8
	assign bus.dev_par_oe  = drv_r;
	// Strobes are driven from the beat they assert, then negated, until the address lines are released
	assign bus.dev_bs_o    = ~bs_r;
	assign bus.dev_xbs_o   = ~xbs_r;
	assign bus.dev_bs_oe   = drv_r && !is_ds_r;
	assign bus.dev_xbs_oe  = drv_r && is_ds_r;
	assign busy            = drv_r;

	// ====================================
	// Snoop and parity check
	logic        snoop_mem, snoop_ds, snoop;
	logic [3:0]  byte_err;
	logic        par_err;
	logic        tag_hit;
	// Only the strobe cycle is sampled; later beats are ignored
	assign snoop_mem = ~bus.xfer_begin_strobe_n && !drv_r; // RL1
	assign snoop_ds  = ~bus.ext_xfer_begin_strobe_n && !drv_r; // RL6 RL7
	assign snoop     = snoop_mem || snoop_ds;
	assign byte_err  = abp_pkg::abp_odd_par(bus.addr_lines) ^ bus.addr_byte_parity; // RL13
	assign par_err   = snoop && (|byte_err); // RL10 RL13
	assign tag_hit   = snoop_ds && bus.addr_lines[abp_pkg::REPLY_FLAG_BIT]
		&& bus.addr_lines[abp_pkg::TAG_LSB +: abp_pkg::TAG_W] == proc_tag_id; // RL6

	logic       err_d1_r, fault_r;
	logic       hit_r, cs_r, mc_r;
	logic [31:0] rword_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			err_d1_r <= 1'b0;
			fault_r  <= 1'b0;
			hit_r    <= 1'b0;
			rword_r  <= abp_pkg::ADDR_RST;
			cs_r     <= 1'b0;
			mc_r     <= 1'b0;
		end else begin
			err_d1_r <= par_err;
			fault_r  <= err_d1_r; // RL12
			hit_r    <= tag_hit && !(|byte_err);
			if (tag_hit) rword_r <= bus.addr_lines; // RL3
			// Checkstop is sticky until reset; machine check is one pulse
			if (par_err && impl_config_reg && !machine_check_enable) cs_r <= 1'b1; // RL10
			mc_r <= par_err && impl_config_reg && machine_check_enable; // RL10
		end
	end

	// Open drain: drive low only when faulting
	assign bus.fault_o  = 1'b0;
	assign bus.fault_oe = fault_r; // RL12
	assign reply_hit     = hit_r;
	assign reply_word    = rword_r;
	assign checkstop     = cs_r;
	assign machine_check = mc_r;
endmodule : abp_dev

// ### abp_sys.sv
// System end: arbiter grant, acknowledge and other-master tenures.
// Assumes one outstanding tenure; the processor end is the other master.
module abp_sys (
	input  wire logic  clk,
	input  wire logic  rst,
	abp_bus_if.sys     bus,
	input  wire logic  grant_req,
	input  wire logic  ack_req,
	input  wire logic  snoop_req,
	input  wire logic  snoop_ds,
	input  wire logic  [31:0] snoop_beat0,
	input  wire logic  [31:0] snoop_beat1,
	input  wire logic  corrupt_par,
	output logic       fault_seen
);
	logic        drv_r, bs_r, xbs_r, two_r, gnt_r, ack_r, flt_r;
	logic [31:0] a_r, b1_r;
	logic [3:0]  p_r;
	logic        start;
	assign start = snoop_req && !drv_r && !(|bus.dev_addr_oe);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			drv_r <= 1'b0;
			bs_r  <= 1'b0;
			xbs_r <= 1'b0;
			two_r <= 1'b0;
			gnt_r <= 1'b0;
			ack_r <= 1'b0;
			flt_r <= 1'b0;
			a_r   <= abp_pkg::ADDR_RST;
			b1_r  <= abp_pkg::ADDR_RST;
			p_r   <= abp_pkg::PAR_RST;
		end else begin
			gnt_r <= grant_req;
			ack_r <= ack_req;
			flt_r <= ~bus.addr_parity_fault_out_n;
			bs_r  <= start && !snoop_ds; // RL1
			xbs_r <= start && snoop_ds; // RL7
			if (start) begin
				drv_r <= 1'b1;
				two_r <= snoop_ds;
				a_r   <= snoop_beat0;
				b1_r  <= snoop_beat1;
				p_r   <= abp_pkg::abp_odd_par(snoop_beat0) ^ {3'h0, corrupt_par}; // RL8
			end else if (two_r) begin
				two_r <= 1'b0;
				a_r   <= b1_r; // RL7
				p_r   <= abp_pkg::abp_odd_par(b1_r);
			end else begin
				drv_r <= 1'b0;
			end
		end
	end

	assign bus.sys_addr_o    = a_r;
	assign bus.sys_par_o     = p_r;
	assign bus.sys_addr_oe   = drv_r;
	assign bus.sys_bs_o      = ~bs_r;
	assign bus.sys_xbs_o     = ~xbs_r;
	assign bus.sys_strobe_oe = drv_r;
	assign bus.grant_n       = ~gnt_r;
	assign bus.addr_ack_in_n = ~ack_r;
	assign fault_seen        = flt_r;
endmodule : abp_sys

// ### abp_props.sv
// Checker for the address-phase bus joining the two ends.
// Assumes bus lines already resolved by the bench.
module abp_props (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [31:0] addr_lines,
	input wire logic [3:0]  addr_byte_parity,
	input wire logic        xfer_begin_strobe_n,
	input wire logic        ext_xfer_begin_strobe_n,
	input wire logic        addr_ack_in_n,
	input wire logic        grant_n,
	input wire logic [31:0] dev_addr_oe,
	input wire logic        dev_par_oe,
	input wire logic        dev_bs_oe,
	input wire logic        dev_xbs_oe,
	input wire logic        fault_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	localparam int FLT_ON  = abp_pkg::FAULT_ASSERT_CYC;
	localparam int FLT_OFF = abp_pkg::FAULT_RELEASE_CYC;
	wire logic [3:0] ep = {~^addr_lines[7:0], ~^addr_lines[15:8],
		~^addr_lines[23:16], ~^addr_lines[31:24]};
	wire logic drv = |dev_addr_oe;
	// Snoop strobe with a bad byte, seen only when the far side drives
	wire logic bad = (!xfer_begin_strobe_n || !ext_xfer_begin_strobe_n) && !drv
		&& addr_byte_parity != ep;
	// ====================================
	// Properties
	property p_par_ok; dev_par_oe |-> addr_byte_parity == ep; endproperty
	a_par_ok: assert property (p_par_ok) else $error("bad parity driven");
	property p_par_follow; dev_par_oe == drv; endproperty
	a_par_follow: assert property (p_par_follow) else $error("parity enable skew");
	property p_mem_grant; dev_bs_oe && !xfer_begin_strobe_n |-> $past(!grant_n); endproperty
	a_mem_grant: assert property (p_mem_grant) else $error("strobe without grant");
	property p_ds_grant; dev_xbs_oe && !ext_xfer_begin_strobe_n |-> $past(!grant_n); endproperty
	a_ds_grant: assert property (p_ds_grant) else $error("ext strobe without grant");
	property p_ds_beat1;
		dev_xbs_oe && !ext_xfer_begin_strobe_n |=> ext_xfer_begin_strobe_n && drv;
	endproperty
	a_ds_beat1: assert property (p_ds_beat1) else $error("second beat lost");
	property p_release; drv && !addr_ack_in_n |=> !drv; endproperty
	a_release: assert property (p_release) else $error("address not released");
	property p_fault_when; fault_oe |-> $past(bad, FLT_ON); endproperty
	a_fault_when: assert property (p_fault_when) else $error("fault without cause");
	property p_fault_on; bad |-> ##FLT_ON fault_oe; endproperty
	a_fault_on: assert property (p_fault_on) else $error("fault not raised");
	property p_fault_rel; bad |-> ##FLT_OFF !fault_oe; endproperty
	a_fault_rel: assert property (p_fault_rel) else $error("fault held too long");
endmodule : abp_props

// ### tb_proc_bus_address_parity.sv
// Bench joining both ends of the address phase over one interface.
// Assumes one 40 ns clock; undriven address lines show a moving pattern.
module tb_proc_bus_address_parity;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst = 1, mem_req = 0, ds_req = 0, cfg = 0, mce = 0;
	logic        grant_req = 0, ack_req = 0, snoop_req = 0, snoop_ds = 0, corrupt_par = 0;
	logic        busy, reply_hit, checkstop, machine_check, fault_seen, hit_s, mc_s, flt_s;
	logic [3:0]  tag = 4'hA;
	logic [31:0] req_addr = 0, req_ctl_tag = 0, beat0 = 0, pat = 32'h5, reply_word, word_s;
	int          n_errors = 0, comparisons = 0, cyc = 0;
	abp_bus_if bus ();
	// ====================================
	// Line resolution: strobes pulled high, fault line open drain
	assign bus.addr_lines = bus.sys_addr_oe ? bus.sys_addr_o
		: (bus.dev_addr_o & bus.dev_addr_oe) | (pat & ~bus.dev_addr_oe);
	assign bus.addr_byte_parity = bus.dev_par_oe ? bus.dev_par_o
		: bus.sys_addr_oe ? bus.sys_par_o : pat[3:0];
	assign bus.xfer_begin_strobe_n = bus.dev_bs_oe ? bus.dev_bs_o
		: bus.sys_strobe_oe ? bus.sys_bs_o : 1'b1;
	assign bus.ext_xfer_begin_strobe_n = bus.dev_xbs_oe ? bus.dev_xbs_o
		: bus.sys_strobe_oe ? bus.sys_xbs_o : 1'b1;
	assign bus.addr_parity_fault_out_n = bus.fault_oe ? bus.fault_o : 1'b1;
	abp_dev abp_dev_inst (.clk(clk), .rst(rst), .bus(bus), .mem_req(mem_req),
		.ds_req(ds_req), .req_addr(req_addr), .req_ctl_tag(req_ctl_tag),
		.proc_tag_id(tag), .impl_config_reg(cfg), .machine_check_enable(mce),
		.busy(busy), .reply_hit(reply_hit), .reply_word(reply_word),
		.checkstop(checkstop), .machine_check(machine_check));
	abp_sys abp_sys_inst (.clk(clk), .rst(rst), .bus(bus), .grant_req(grant_req),
		.ack_req(ack_req), .snoop_req(snoop_req), .snoop_ds(snoop_ds),
		.snoop_beat0(beat0), .snoop_beat1(~beat0), .corrupt_par(corrupt_par),
		.fault_seen(fault_seen));
	abp_props abp_props_inst (.clk(clk), .rst(rst), .addr_lines(bus.addr_lines),
		.addr_byte_parity(bus.addr_byte_parity),
		.xfer_begin_strobe_n(bus.xfer_begin_strobe_n),
		.ext_xfer_begin_strobe_n(bus.ext_xfer_begin_strobe_n),
		.addr_ack_in_n(bus.addr_ack_in_n), .grant_n(bus.grant_n),
		.dev_addr_oe(bus.dev_addr_oe), .dev_par_oe(bus.dev_par_oe),
		.dev_bs_oe(bus.dev_bs_oe), .dev_xbs_oe(bus.dev_xbs_oe), .fault_oe(bus.fault_oe));
	always #20 clk = ~clk;
	// ====================================
	// Pulse capture and hang limit
	always @(posedge clk) begin
		pat <= {pat[30:0], ~pat[31]};
		cyc++;
		if (reply_hit === 1'b1) begin
			hit_s = 1;
			word_s = reply_word;
		end
		if (machine_check === 1'b1) mc_s = 1;
		if (fault_seen === 1'b1) flt_s = 1;
		if (cyc == 2000) begin
			n_errors++;
			finish_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : tick
	task automatic wait_strobe();
		for (int k = 0; k < 20 && bus.xfer_begin_strobe_n && bus.ext_xfer_begin_strobe_n; k++)
			tick(1);
	endtask : wait_strobe
	function automatic logic [3:0] odd4(input logic [31:0] a);
		return {~^a[7:0], ~^a[15:8], ~^a[23:16], ~^a[31:24]};
	endfunction : odd4
	// Ack one cycle, then confirm the lines are let go
	task automatic ack_release(input logic [31:0] a);
		ack_req = 1;
		tick(1);
		ack_req = 0;
		chk("held", bus.addr_lines, a);
		chk("busy held", {31'h0, busy}, 32'h1);
		tick(1);
		chk("released", {31'h0, |bus.dev_addr_oe}, 0);
		chk("busy released", {31'h0, busy}, 32'h0);
	endtask : ack_release
	task automatic t_mem();
		req_addr = 32'h8421_F00E;
		mem_req = 1;
		grant_req = 1;
		wait_strobe();
		mem_req = 0;
		grant_req = 0;
		chk("mem strobe", {31'h0, bus.xfer_begin_strobe_n}, 0);
		chk("mem addr", bus.addr_lines, req_addr);
		chk("mem par", {28'h0, bus.addr_byte_parity}, {28'h0, odd4(req_addr)});
		ack_release(req_addr);
		$display("test mem done");
	endtask : t_mem
	task automatic t_ds();
		req_ctl_tag = 32'h3C00_0055;
		req_addr = 32'h0000_1FF0;
		ds_req = 1;
		grant_req = 1;
		wait_strobe();
		ds_req = 0;
		grant_req = 0;
		chk("ds strobe", {31'h0, bus.ext_xfer_begin_strobe_n}, 0);
		chk("ds beat0", bus.addr_lines, req_ctl_tag);
		tick(1);
		chk("ds beat1", bus.addr_lines, req_addr);
		chk("ds par", {28'h0, bus.addr_byte_parity}, {28'h0, odd4(req_addr)});
		ack_release(req_addr);
		$display("test ds done");
	endtask : t_ds
	task automatic snoop(input logic [31:0] b0, input logic ds, input logic bad);
		hit_s = 0;
		mc_s = 0;
		flt_s = 0;
		beat0 = b0;
		snoop_ds = ds;
		corrupt_par = bad;
		snoop_req = 1;
		wait_strobe();
		snoop_req = 0;
		chk("snoop addr", bus.addr_lines, b0);
		if (ds) begin
			tick(1);
			chk("snoop beat1", bus.addr_lines, ~b0);
		end
		tick(6);
	endtask : snoop
	task automatic t_reply();
		cfg = 1;
		mce = 1;
		snoop(32'h8A00_5A5A, 1, 0);
		chk("hit", {31'h0, hit_s}, 1);
		chk("word", word_s, 32'h8A00_5A5A);
		snoop(32'h8500_5A5A, 1, 0);
		chk("tag miss", {31'h0, hit_s}, 0);
		snoop(32'h8A00_5A5A, 0, 0);
		chk("mem no hit", {31'h0, hit_s | flt_s}, 0);
		$display("test reply done");
	endtask : t_reply
	task automatic t_perr();
		snoop(32'h1234_5678, 0, 1);
		chk("mc", {31'h0, mc_s}, 1);
		chk("fault", {31'h0, flt_s}, 1);
		cfg = 0;
		mce = 0;
		snoop(32'h1234_5678, 0, 1);
		chk("off", {31'h0, mc_s | checkstop}, 0);
		cfg = 1;
		snoop(32'h8A00_0001, 1, 1);
		chk("cs", {30'h0, checkstop, mc_s}, 2);
		chk("ds fault", {31'h0, flt_s}, 1);
		chk("bad no hit", {31'h0, hit_s}, 0);
		$display("test perr done");
	endtask : t_perr
	// Mid-run reset must clear the sticky checkstop and allow a fresh tenure
	task automatic t_rst();
		rst = 1;
		tick(2);
		rst = 0;
		chk("cs cleared", {31'h0, checkstop}, 0);
		tick(2);
		t_mem();
		$display("test reset done");
	endtask : t_rst
	task automatic finish_test();
		$display("checks %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	initial begin
		tick(10);
		rst = 0;
		t_mem();
		t_ds();
		t_reply();
		t_perr();
		t_rst();
		finish_test();
	end
endmodule : tb_proc_bus_address_parity
